/* verilog/pcg_top.sv */
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module pcg_top (
    // Clock, reset, clock enable
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    // Register port
    input wire logic [pcg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pcg_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pcg_pkg::DATA_W-1:0] reg_rdata,
    // System state
    input wire logic stop_mode,
    input wire logic pll_sys_sel,
    // Peripheral interrupt requests
    input wire logic [15:0] periph_irq0,
    input wire logic [15:0] periph_irq1,
    // Peripheral clock state
    output logic [15:0] periph_run0,
    output logic [15:0] periph_run1,
    output logic [15:0] periph_hold0,
    output logic [15:0] periph_hold1,
    output logic [15:0] periph_gclk0,
    output logic [15:0] periph_gclk1,
    // Two-wire rate and wake-up
    output logic twowire_run_3x,
    output logic wake_req
);
    import pcg_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] pce0;
        logic [15:0] pce1;
        logic [15:0] sd0;
        logic rate;
        logic [15:0] rdata;
        logic rate3x;
        logic wake;
    } pcg_state_t;

    pcg_state_t st;
    pcg_state_t next_st;
    logic [15:0] keep_now;

    pcg_run_if rif ();

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    // The register map is laid out for 5-bit addresses and 16-bit words
    if (ADDR_W != 5 || DATA_W != 16)
    begin : g_geom_bad
        $error("register port geometry not supported");
    end

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    // Address match, used by both strobes
    function automatic logic hit(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] ofs
    );
        hit = (a == ofs);
    endfunction

    // Read mux; unmapped words read zero
    function automatic logic [15:0] rd_mux(
        input logic [ADDR_W-1:0] a,
        input pcg_state_t s,
        input logic [15:0] r0,
        input logic [15:0] r1
    );
        logic [15:0] v;
        v = 16'h0000;
        if (hit(a, OFS_RATE))
            v = s.rate ? RATE_MASK : 16'h0000;
        else if (hit(a, OFS_PCE0))
            v = s.pce0 & PCE0_MASK;
        else if (hit(a, OFS_PCE1))
            v = s.pce1 & PCE1_MASK;
        else if (hit(a, OFS_SD0))
            v = s.sd0 & SD0_MASK;
        else if (hit(a, OFS_STAT0))
            v = r0;
        else if (hit(a, OFS_STAT1))
            v = r1;
        rd_mux = v;
    endfunction

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb
    begin
        next_st = st;
        if (clk_en)
        begin
            // Read data stands one cycle only
            next_st.rdata = 16'h0000;
            if (reg_rd)
                next_st.rdata = rd_mux(reg_addr, st,
                    rif.run0, rif.run1);
            // Reserved bits are never stored
            if (reg_wr)
            begin
                if (hit(reg_addr, OFS_RATE))
                    next_st.rate =
                        reg_wdata[TWOWIRE_RUN_RATE_SEL];
                if (hit(reg_addr, OFS_PCE0))
                    next_st.pce0 = reg_wdata & PCE0_MASK;
                if (hit(reg_addr, OFS_PCE1))
                    next_st.pce1 = reg_wdata & PCE1_MASK;
                if (hit(reg_addr, OFS_SD0))
                    next_st.sd0 = reg_wdata & SD0_MASK;
            end
            // Triple clock needs the loop as system clock
            next_st.rate3x = st.rate & pll_sys_sel;
            // Only still-clocked peripherals can raise a wake
            next_st.wake = stop_mode &
                (|(periph_irq0 & rif.run0) |
                 |(periph_irq1 & rif.run1));
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Reset clears every keep bit, so stop gates all
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '0;
            st.pce0 <= PCE0_RST;
            st.pce1 <= PCE1_RST;
            st.sd0 <= SD0_RST;
            st.rate <= RATE_RST;
        end
        else
            st <= next_st;
    end

    // ----------------------------------------
    // Sub-blocks
    // ----------------------------------------
    assign rif.pce0 = st.pce0;
    assign rif.pce1 = st.pce1;
    assign rif.sd0 = st.sd0;
    assign rif.stop_mode = stop_mode;

    pcg_stop_ctrl u_ctrl (
        .mclk(mclk),
        .resetn(resetn),
        .clk_en(clk_en),
        .rif(rif.ctrl)
    );

    // Gated clocks follow a gate, not a flop
    pcg_clk_gate u_gate (
        .mclk(mclk),
        .resetn(resetn),
        .clk_en(clk_en),
        .rif(rif.gate),
        .gclk0(periph_gclk0),
        .gclk1(periph_gclk1)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata = st.rdata;
    assign periph_run0 = rif.run0;
    assign periph_run1 = rif.run1;
    assign periph_hold0 = rif.hold0;
    assign periph_hold1 = rif.hold1;
    assign twowire_run_3x = st.rate3x;
    assign wake_req = st.wake;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    assign keep_now = st.pce0 & st.sd0;

    chk_rate_store: assert property (
        (clk_en && reg_wr && hit(reg_addr, OFS_RATE))
        |=> (st.rate == $past(reg_wdata[TWOWIRE_RUN_RATE_SEL])))
        else $error("rate select not stored");

    chk_no_pll_3x: assert property (
        (!pll_sys_sel) [*2] |-> !twowire_run_3x)
        else $error("triple clock chosen without loop");

    chk_rsvd_read: assert property (
        (clk_en && reg_rd && hit(reg_addr, OFS_SD0))
        |=> ((reg_rdata & ~SD0_MASK) == 16'h0000))
        else $error("reserved keep bit read as one");

    chk_enable_run: assert property (
        (clk_en && !stop_mode && reg_wr && hit(reg_addr, OFS_PCE0))
        ##1 (clk_en && !stop_mode && !reg_wr)
        |=> (periph_run0 == ($past(reg_wdata, 2) & PCE0_MASK)))
        else $error("enable write did not reach clock");

    chk_stop_keep: assert property (
        (clk_en && stop_mode)
        |=> ((periph_run0 & ~$past(keep_now)) == 16'h0000))
        else $error("unkept clock runs in stop");

    chk_stop_reg1: assert property (
        (clk_en && stop_mode) |=> (periph_run1 == 16'h0000))
        else $error("timer clock runs in stop");

    chk_hold_tie: assert property (
        periph_hold0 == (~periph_run0 & PCE0_MASK))
        else $error("hold does not mirror gated clock");

    chk_wake_irq: assert property (
        (clk_en && stop_mode && (|(periph_irq0 & periph_run0)))
        |=> wake_req)
        else $error("kept peripheral interrupt did not wake");

    chk_read_once: assert property (
        (clk_en && !reg_rd) |=> (reg_rdata == 16'h0000))
        else $error("read data outlived its cycle");

    // Both enable registers keep hold and run in step
    chk_hold_reg1: assert property (
        periph_hold1 == (~periph_run1 & PCE1_MASK))
        else $error("second hold does not mirror gated clock");

    chk_run1_follow: assert property (
        (clk_en && !stop_mode)
        |=> (periph_run1 == ($past(st.pce1) & PCE1_MASK)))
        else $error("second enable did not reach clock");

    // In stop the kept set is exact, not only a bound
    chk_keep_exact: assert property (
        (clk_en && stop_mode)
        |=> (periph_run0 == $past(keep_now & SD0_MASK)))
        else $error("kept clock set differs in stop");

    chk_wake_quiet: assert property (
        (clk_en && !stop_mode) |=> !wake_req)
        else $error("wake raised outside stop");

    // Reserved bits of every register read as zero
    chk_rsvd_pce0: assert property (
        (clk_en && reg_rd && hit(reg_addr, OFS_PCE0))
        |=> ((reg_rdata & ~PCE0_MASK) == 16'h0000))
        else $error("reserved enable bit read as one");

    chk_rsvd_pce1: assert property (
        (clk_en && reg_rd && hit(reg_addr, OFS_PCE1))
        |=> ((reg_rdata & ~PCE1_MASK) == 16'h0000))
        else $error("reserved timer enable bit read as one");

    chk_rate_read: assert property (
        (clk_en && reg_rd && hit(reg_addr, OFS_RATE))
        |=> (reg_rdata == ($past(st.rate) ? RATE_MASK : 16'h0000)))
        else $error("rate select read back wrong");

    cov_enable_write: cover property (
        reg_wr && hit(reg_addr, OFS_PCE0) ##2 (periph_run0 != 16'h0000));

    cov_stop_kept: cover property (
        stop_mode && (periph_run0 != 16'h0000));

    cov_wake: cover property (
        stop_mode ##1 wake_req);

    cov_triple: cover property (
        twowire_run_3x);

    cov_twowire_kept: cover property (
        stop_mode && periph_run0[TWOWIRE_CLK_EN]);

endmodule
`default_nettype wire

/* verilog/pcg_pkg.sv */
package pcg_pkg;

    // ----------------------------------------
    // Bus geometry
    // ----------------------------------------
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    // ----------------------------------------
    // Register word offsets
    // ----------------------------------------
    localparam logic [4:0] OFS_RATE = 5'h0B;
    localparam logic [4:0] OFS_PCE0 = 5'h0C;
    localparam logic [4:0] OFS_PCE1 = 5'h0D;
    localparam logic [4:0] OFS_SD0 = 5'h0E;
    localparam logic [4:0] OFS_STAT0 = 5'h18;
    localparam logic [4:0] OFS_STAT1 = 5'h19;

    // ----------------------------------------
    // Field positions, enable register 0
    // ----------------------------------------
    localparam int COMPARATOR_B_CLK_EN = 15;
    localparam int COMPARATOR_A_CLK_EN = 14;
    localparam int ANALOG_OUT1_CLK_EN = 13;
    localparam int ANALOG_OUT0_CLK_EN = 12;
    localparam int ANALOG_IN_CLK_EN = 10;
    localparam int TWOWIRE_CLK_EN = 6;
    localparam int ASYNC_SERIAL_CLK_EN = 4;
    localparam int SYNC_SERIAL_CLK_EN = 2;
    localparam int MODULATOR_CLK_EN = 0;

    // ----------------------------------------
    // Field positions, enable register 1
    // ----------------------------------------
    localparam int INTERVAL_TIMER_CLK_EN = 12;
    localparam int TIMER_CH3_CLK_EN = 3;
    localparam int TIMER_CH0_CLK_EN = 0;

    // Rate register: two-wire run clock select
    localparam int TWOWIRE_RUN_RATE_SEL = 12;

    // ----------------------------------------
    // Implemented-bit masks and reset values
    // ----------------------------------------
    localparam logic [15:0] PCE0_MASK = 16'hF455;
    localparam logic [15:0] PCE1_MASK = 16'h100F;
    localparam logic [15:0] SD0_MASK = 16'hF455;
    localparam logic [15:0] RATE_MASK = 16'h1000;
    localparam logic [15:0] PCE0_RST = 16'h0000;
    localparam logic [15:0] PCE1_RST = 16'h0000;
    localparam logic [15:0] SD0_RST = 16'h0000;
    localparam logic RATE_RST = 1'b0;
    // Second keep-alive register is not built
    localparam logic [15:0] SD1_FIXED = 16'h0000;

endpackage

/* verilog/pcg_run_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface pcg_run_if;
    import pcg_pkg::*;
    // Programmed register contents and stop mode
    logic [15:0] pce0;
    logic [15:0] pce1;
    logic [15:0] sd0;
    logic stop_mode;
    // Live clock state per peripheral
    logic [15:0] run0;
    logic [15:0] run1;
    logic [15:0] hold0;
    logic [15:0] hold1;

    modport src (
        output pce0, pce1, sd0, stop_mode,
        input run0, run1, hold0, hold1
    );
    modport ctrl (
        input pce0, pce1, sd0, stop_mode,
        output run0, run1, hold0, hold1
    );
    modport gate (
        input run0, run1
    );
endinterface
`default_nettype wire

/* verilog/pcg_stop_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module pcg_stop_ctrl (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    // Register contents in, clock state out
    pcg_run_if.ctrl rif
);
    import pcg_pkg::*;

    typedef struct packed {
        logic [15:0] run0;
        logic [15:0] run1;
        logic [15:0] hold0;
        logic [15:0] hold1;
    } pcg_ctl_t;

    pcg_ctl_t st;
    pcg_ctl_t next_st;
    logic [15:0] keep0;

    // ----------------------------------------
    // Run and hold decision
    // ----------------------------------------
    // Keep-alive needs the enable too
    assign keep0 = rif.pce0 & rif.sd0 & SD0_MASK;

    always_comb
    begin
        next_st = st;
        if (clk_en)
        begin
            // Stop mode drops all but kept clocks
            if (rif.stop_mode)
            begin
                next_st.run0 = keep0;
                next_st.run1 = rif.pce1 & SD1_FIXED;
            end
            else
            begin
                next_st.run0 = rif.pce0 & PCE0_MASK;
                next_st.run1 = rif.pce1 & PCE1_MASK;
            end
            // Gated peripheral held stopped, bus ignored
            next_st.hold0 = ~next_st.run0 & PCE0_MASK;
            next_st.hold1 = ~next_st.run1 & PCE1_MASK;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '0;
            // Every unit starts gated, so it starts held too
            st.hold0 <= PCE0_MASK;
            st.hold1 <= PCE1_MASK;
        end
        else
            st <= next_st;
    end

    assign rif.run0 = st.run0;
    assign rif.run1 = st.run1;
    assign rif.hold0 = st.hold0;
    assign rif.hold1 = st.hold1;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_keep_needs_en: assert property (
        @(posedge mclk) disable iff (!resetn)
        (clk_en && rif.stop_mode) |=> ((st.run0 & ~$past(keep0)) == 16'h0000))
        else $error("clock kept in stop without enable and keep bit");

endmodule
`default_nettype wire

/* verilog/pcg_clk_gate.sv */
`timescale 1ns/1ns
`default_nettype none
module pcg_clk_gate (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    // Gate requests
    pcg_run_if.gate rif,
    // Gated clocks
    output logic [15:0] gclk0,
    output logic [15:0] gclk1
);
    import pcg_pkg::*;

    typedef struct packed {
        logic [31:0] en_lo;
    } pcg_gate_t;

    pcg_gate_t st;
    pcg_gate_t next_st;
    logic [31:0] req;
    logic [31:0] gclk;

    assign req = {rif.run1, rif.run0};

    always_comb
    begin
        next_st = st;
        if (clk_en)
            next_st.en_lo = req;
    end

    // ----------------------------------------
    // Enable taken while the clock is low
    // ----------------------------------------
    // Falling-edge capture keeps the AND free of runt pulses
    always_ff @(negedge mclk or negedge resetn)
    begin
        if (!resetn)
            st <= '0;
        else
            st <= next_st;
    end

    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1)
        begin : g_and
            assign gclk[i] = mclk & st.en_lo[i];
        end
    endgenerate

    assign gclk0 = gclk[15:0];
    assign gclk1 = gclk[31:16];

    chk_gate_follows: assert property (
        @(posedge mclk) disable iff (!resetn)
        clk_en |-> (st.en_lo == req))
        else $error("gate enable did not follow request");

endmodule
`default_nettype wire

/* bench/pcg_periph_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Gated peripherals: each samples its request on its own clock
// ----------------------------------------
module pcg_periph_model (
    // Reset
    input wire logic resetn,
    // Gated clocks
    input wire logic [15:0] gclk0,
    input wire logic [15:0] gclk1,
    // Requests commanded by the bench
    input wire logic [15:0] irq_cmd0,
    input wire logic [15:0] irq_cmd1,
    // Interrupt levels and activity toggles
    output logic [15:0] irq0,
    output logic [15:0] irq1,
    output logic [15:0] tick0,
    output logic [15:0] tick1
);
    // An unclocked peripheral freezes, so it neither ticks nor raises
    for (genvar i = 0; i < 16; i++)
    begin : g_bit
        logic [1:0] q0;
        logic [1:0] q1;
        always_ff @(posedge gclk0[i] or negedge resetn)
        begin
            if (!resetn)
                q0 <= 2'h0;
            else
                q0 <= {irq_cmd0[i], ~q0[0]};
        end
        always_ff @(posedge gclk1[i] or negedge resetn)
        begin
            if (!resetn)
                q1 <= 2'h0;
            else
                q1 <= {irq_cmd1[i], ~q1[0]};
        end
        assign irq0[i] = q0[1];
        assign tick0[i] = q0[0];
        assign irq1[i] = q1[1];
        assign tick1[i] = q1[0];
    end
endmodule
`default_nettype wire

/* bench/peripheral_clock_gating_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module peripheral_clock_gating_tb;
    import pcg_pkg::*;
    logic mclk = 1'b0, resetn = 1'b0, clk_en = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, stop_mode = 1'b0, pll_sys_sel = 1'b0;
    logic [15:0] irq0, irq1, run0, run1, hold0, hold1, gclk0, gclk1;
    logic [15:0] cmd0 = 16'h0000, cmd1 = 16'h0000, tick0, tick1, t0, t1;
    logic twowire_run_3x, wake_req, e_rate;
    logic [15:0] e_pce0, e_pce1, e_sd0, d;
    int err_total = 0, tests_run = 0, cyc = 0;

    // ----------------------------------------
    // Clock, timeout, design and peripherals
    // ----------------------------------------
    always #20 mclk = ~mclk;
    // A hang is cut well past the roughly one thousand cycles the tests need
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            wrap_up();
        end
    end
    pcg_top u_dut (.mclk(mclk), .resetn(resetn), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_mode(stop_mode),
        .pll_sys_sel(pll_sys_sel), .periph_irq0(irq0), .periph_irq1(irq1),
        .periph_run0(run0), .periph_run1(run1), .periph_hold0(hold0),
        .periph_hold1(hold1), .periph_gclk0(gclk0), .periph_gclk1(gclk1),
        .twowire_run_3x(twowire_run_3x), .wake_req(wake_req));
    pcg_periph_model u_periph (.resetn(resetn), .gclk0(gclk0),
        .gclk1(gclk1), .irq_cmd0(cmd0), .irq_cmd1(cmd1), .irq0(irq0),
        .irq1(irq1), .tick0(tick0), .tick1(tick1));

    // ----------------------------------------
    // Bus tasks and expectations
    // ----------------------------------------
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // Data stand only in the cycle after the read strobe
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    function automatic logic [15:0] exp_rd(input logic [4:0] a);
        case (a)
            OFS_RATE: return {3'h0, e_rate, 12'h000};
            OFS_PCE0: return e_pce0;
            OFS_PCE1: return e_pce1;
            OFS_SD0: return e_sd0;
            OFS_STAT0: return stop_mode ? (e_pce0 & e_sd0) : e_pce0;
            OFS_STAT1: return stop_mode ? 16'h0000 : e_pce1;
            default: return 16'h0000;
        endcase
    endfunction
    // Compare every mapped place plus two unmapped ones
    task automatic check_all();
        logic [4:0] al [8] = '{OFS_RATE, OFS_PCE0, OFS_PCE1, OFS_SD0,
            OFS_STAT0, OFS_STAT1, 5'h0F, 5'h1F};
        repeat (2) @(posedge mclk);
        #1;
        `CHK(run0, exp_rd(OFS_STAT0))
        `CHK(run1, exp_rd(OFS_STAT1))
        `CHK(hold0, ~run0 & PCE0_MASK)
        `CHK(hold1, ~run1 & PCE1_MASK)
        `CHK(twowire_run_3x, e_rate & pll_sys_sel)
        foreach (al[k])
        begin
            rd(al[k], d);
            `CHK(d, exp_rd(al[k]))
        end
        t0 = tick0;
        t1 = tick1;
        repeat (3) @(posedge mclk);
        #1;
        `CHK(tick0 ^ t0, run0)
        `CHK(tick1 ^ t1, run1)
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(50));
        {e_pce0, e_pce1, e_sd0, e_rate} = '0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        // Reset state: all clocks off, stop gates everything
        check_all();
        // Random programming; reserved bits kept at zero
        for (int i = 0; i < 24; i++)
        begin
            stop_mode <= 1'($urandom);
            pll_sys_sel <= 1'($urandom);
            // Two-wire unit is switched off while its rate changes
            e_pce0[TWOWIRE_CLK_EN] = 1'b0;
            wr(OFS_PCE0, e_pce0);
            d = 16'($urandom) & RATE_MASK;
            wr(OFS_RATE, d);
            e_rate = d[TWOWIRE_RUN_RATE_SEL];
            d = 16'($urandom) & PCE0_MASK;
            wr(OFS_PCE0, d);
            e_pce0 = d;
            d = 16'($urandom) & PCE1_MASK;
            wr(OFS_PCE1, d);
            e_pce1 = d;
            d = 16'($urandom) & SD0_MASK;
            wr(OFS_SD0, d);
            e_sd0 = d;
            wr(5'h1F, 16'hFFFF);
            check_all();
        end
        // Writes with the clock enable low are ignored
        clk_en <= 1'b0;
        wr(OFS_PCE0, ~e_pce0 & PCE0_MASK);
        @(posedge mclk);
        clk_en <= 1'b1;
        check_all();
        // Stop mode: unkept units disabled first, only two-wire runs
        stop_mode <= 1'b0;
        wr(OFS_SD0, 16'h0040);
        wr(OFS_PCE0, 16'h0040);
        wr(OFS_PCE1, 16'h0000);
        {e_pce0, e_sd0, e_pce1} = {16'h0040, 16'h0040, 16'h0000};
        @(posedge mclk);
        stop_mode <= 1'b1;
        check_all();
        // Request from an unclocked unit never wakes the system
        cmd0 <= 16'h0010;
        cmd1 <= 16'h1000;
        repeat (5) @(posedge mclk);
        #1;
        `CHK(wake_req, 1'b0)
        // Request from the kept unit wakes within a few cycles
        cmd0 <= 16'h0050;
        repeat (4) @(posedge mclk);
        #1;
        `CHK(irq0, 16'h0040)
        `CHK(wake_req, 1'b1)
        // Leaving stop, then every unit enabled again
        cmd0 <= 16'h0000;
        cmd1 <= 16'h0000;
        stop_mode <= 1'b0;
        wr(OFS_PCE0, PCE0_MASK);
        wr(OFS_PCE1, PCE1_MASK);
        {e_pce0, e_pce1} = {PCE0_MASK, PCE1_MASK};
        check_all();
        wrap_up();
    end
endmodule
`default_nettype wire
